//--- flash_dev_model.sv
// Purpose: behavioural parallel flash seen by the controller
// Assumes: codes from flash_host_map.svh, timed on the controller clock
// Notes: status returned at any address while busy and not suspended, a simplification
`timescale 1ns/1ps
`include "flash_host_map.svh"
module flash_dev_model
  import flash_host_pkg::*;
#(parameter int PROG_CYC = 60, parameter int ERASE_CYC = 300)
(
  input wire logic clk_in,
  input wire flash_bus_t bus_in,
  input wire logic reset_n_in,
  input wire logic supply_low_in,
  output logic [15:0] dq_out
);
  logic [15:0] mem [int];
  logic [15:0] hist [3];
  logic [15:0] val, pd, d;
  logic [15:0] last = 16'h0000;
  logic [511:0] locked;
  logic [20:0] pa, a;
  logic [1:0] cfg = 2'h0; // power-up value, untouched by the reset pin
  logic busy, susp, ers, chip, failed, done01, idm, tog, pend_p, pend_c, we_q, rd_q;
  int left;
  assign d = bus_in.dq;
  assign a = bus_in.addr;
  ////////////////////////////////////////////////////////////////////////////////
  // read value; released pins show the inverse so a stale sample is caught
  always_comb
  begin
    if (busy && !susp) val = {8'h00, (cfg == 2'h0) && !ers && !pd[7], tog, 6'h00};
    else if (failed) val = {8'h00, 1'b1, tog, !supply_low_in, 1'b0, supply_low_in, 3'h0};
    else if (done01) val = 16'h0080;
    else if (idm && a[11:0] == `LOCK_OFFSET) val = {15'h0000, locked[a[20:12]]};
    else val = mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
  end
  assign dq_out = (!bus_in.ce_n && !bus_in.oe_n) ? val : ~last;
  // timer, reset and command decode
  always @(posedge clk_in)
  begin
    we_q <= bus_in.we_n;
    rd_q <= !bus_in.ce_n && !bus_in.oe_n;
    if (!bus_in.ce_n && !bus_in.oe_n) last <= val;
    if (rd_q && bus_in.oe_n && (busy && !susp || failed)) tog <= !tog;
    if (!reset_n_in)
    begin
      if (busy && !ers) mem[int'(pa)] = pd ^ 16'h5A5A;
      {busy, susp, failed, done01, idm, pend_p, pend_c, tog} <= 8'h00;
      locked <= 512'h0;
    end
    else if (busy && !susp && left == 0)
    begin
      foreach (mem[k]) if (ers && !locked[k[20:12]] && (chip || k[20:12] == pa[20:12])) mem[k] = 16'hFFFF;
      if (!ers) mem[int'(pa)] = (mem.exists(int'(pa)) ? mem[int'(pa)] : 16'hFFFF) & pd;
      busy <= 1'b0;
      done01 <= cfg == 2'h1;
    end
    else if (busy && !susp) left <= left - 1;
    if (reset_n_in && bus_in.we_n && !we_q && !bus_in.ce_n)
    begin
      hist <= '{d, hist[0], hist[1]};
      if (busy) susp <= susp ? d != `RESUME_CMD : d == `SUSPEND_CMD;
      else if (pend_c) {pend_c, cfg} <= {1'b0, d[1:0]};
      else if (pend_p)
      begin
        {pend_p, ers, pa, pd, left} <= {1'b0, 1'b0, a, d, PROG_CYC};
        if (locked[a[20:12]] || supply_low_in) failed <= 1'b1;
        else busy <= 1'b1;
      end
      else if (hist[1] == `UNLOCK1_DATA && hist[0] == `UNLOCK2_DATA)
      begin
        pend_p <= d == `PROG_CMD;
        pend_c <= d == `SET_CFG_CMD;
        if (d == `ID_ENTRY_CMD) idm <= 1'b1;
        if (d == `ID_EXIT_CMD) {idm, failed, done01} <= 3'h0;
        if (hist[2] == `ERASE_SETUP_CMD && d == `LOCKDOWN_CMD) locked[a[20:12]] <= 1'b1;
        if (hist[2] == `ERASE_SETUP_CMD && (d == `SECT_ERASE_CMD || d == `CHIP_ERASE_CMD))
        begin
          {pa, ers, chip, left} <= {a, 1'b1, d == `CHIP_ERASE_CMD, ERASE_CYC};
          if (supply_low_in || d == `SECT_ERASE_CMD && locked[a[20:12]]) failed <= 1'b1;
          else busy <= 1'b1;
        end
      end
    end
  end
endmodule : flash_dev_model

//--- flash_host_ctrl.sv
// Purpose: host side controller that issues flash command sequences and polls status
// Assumes: flash BYTE pin tied for word mode, flash inputs synchronous to sys_clk_in
// Notes: one user command at a time; suspend is a separate request pulse
`timescale 1ns/1ps
`include "flash_host_map.svh"

module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter logic [23:0] POLL_LIMIT = `POLL_LIMIT_CYC
)
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic cmd_valid_in,
  input wire op_t cmd_op_in,
  input wire logic [20:0] cmd_addr_in,
  input wire logic [15:0] cmd_data_in,
  input wire logic suspend_req_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic rsp_fail_out,
  output logic [15:0] rsp_data_out,
  output logic rsp_locked_out,
  output logic suspended_out,
  output logic [1:0] status_cfg_out,
  output flash_bus_t flash_bus_out,
  input wire logic [15:0] flash_dq_in,
  output logic flash_reset_n_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // command sequence table
  function automatic bus_cycle_t seq_cycle(input op_t op, input logic [2:0] idx,
                                           input logic [20:0] a, input logic [15:0] d);
    bus_cycle_t c;
    c.last = 1'b0;
    c.addr = (idx == 3'h1 || idx == 3'h4) ? `UNLOCK2_ADDR : `UNLOCK1_ADDR;
    c.data = (idx == 3'h1 || idx == 3'h4) ? `UNLOCK2_DATA : `UNLOCK1_DATA;
    if (op == OP_SUSPEND || op == OP_RESUME)
    begin
      c.addr = 21'h000000;
      c.data = (op == OP_SUSPEND) ? `SUSPEND_CMD : `RESUME_CMD;
      c.last = 1'b1;
    end
    else if (idx == 3'h2)
    begin
      case (op)
        OP_PROGRAM: c.data = `PROG_CMD;
        OP_SET_CFG: c.data = `SET_CFG_CMD;
        OP_ID_ENTRY: c.data = `ID_ENTRY_CMD;
        OP_ID_EXIT: c.data = `ID_EXIT_CMD;
        default: c.data = `ERASE_SETUP_CMD;
      endcase
      c.last = (op == OP_ID_ENTRY || op == OP_ID_EXIT);
    end
    else if (idx == 3'h3 && (op == OP_PROGRAM || op == OP_SET_CFG))
    begin
      c.addr = (op == OP_PROGRAM) ? a : `UNLOCK1_ADDR;
      c.data = (op == OP_PROGRAM) ? d : {14'h0000, d[1:0]};
      c.last = 1'b1;
    end
    else if (idx == 3'h5)
    begin
      c.addr = (op == OP_CHIP_ERASE) ? `UNLOCK1_ADDR : a;
      c.data = (op == OP_CHIP_ERASE) ? `CHIP_ERASE_CMD :
               (op == OP_LOCKDOWN) ? `LOCKDOWN_CMD : `SECT_ERASE_CMD;
      c.last = 1'b1;
    end
    return c;
  endfunction : seq_cycle

  ////////////////////////////////////////////////////////////////////////////////
  // state
  state_t state;
  op_t seq_op;
  rd_kind_t rd_kind;
  logic [2:0] seq_idx;
  logic [20:0] op_addr;
  logic [15:0] op_data;
  logic [20:0] poll_addr;
  logic [20:0] susp_addr;
  logic [15:0] rd_a;
  logic [15:0] rd_b;
  logic op_erase;
  logic susp_erase;
  logic nested;
  logic recheck;
  logic fail;
  logic pending;
  logic [7:0] wait_cnt;
  logic [23:0] poll_cnt;
  logic [2:0] rst_cnt;
  bus_cycle_t cur_c;
  logic [20:0] rd_addr;
  logic toggled;
  logic err_bits;

  // decode of the current write cycle and read address
  assign cur_c = seq_cycle(seq_op, seq_idx, op_addr, op_data);
  assign rd_addr = (rd_kind == RD_USER) ? op_addr :
                   (rd_kind == RD_LOCK) ? {op_addr[20:12], `LOCK_OFFSET} : poll_addr;
  assign toggled = rd_a[`TOGGLE_BIT] ^ rd_b[`TOGGLE_BIT];
  assign err_bits = rd_b[`FAIL_BIT] | rd_b[`SUPPLY_LOW_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // flash reset pin: pulsed only at controller reset, never mid-operation
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_cnt <= 3'h0;
      flash_reset_n_out <= 1'b0;
    end
    else if (rst_cnt != 3'(`RESET_LOW_CYC))
    begin
      rst_cnt <= rst_cnt + 3'h1;
    end
    else
    begin
      flash_reset_n_out <= 1'b1;
    end
  end

  // suspend request latch; a new request wins over the clear
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      pending <= 1'b0;
    else
      pending <= (pending & ~((state == ST_POLL_CHK && !suspended_out) ||
                  state == ST_FINISH)) | suspend_req_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequencer
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state <= ST_RST_HOLD;
      seq_op <= OP_READ;
      rd_kind <= RD_USER;
      seq_idx <= 3'h0;
      op_addr <= 21'h000000;
      op_data <= 16'h0000;
      poll_addr <= 21'h000000;
      susp_addr <= 21'h000000;
      rd_a <= 16'h0000;
      rd_b <= 16'h0000;
      op_erase <= 1'b0;
      susp_erase <= 1'b0;
      nested <= 1'b0;
      recheck <= 1'b0;
      fail <= 1'b0;
      wait_cnt <= 8'h00;
      poll_cnt <= 24'h000000;
      cmd_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_fail_out <= 1'b0;
      rsp_data_out <= 16'h0000;
      rsp_locked_out <= 1'b0;
      suspended_out <= 1'b0;
      status_cfg_out <= `CFG_RESET;
      flash_bus_out <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 21'h000000,
                         dq: 16'h0000, dq_oe: 1'b0};
    end
    else
    begin
      rsp_valid_out <= 1'b0;
      if (poll_cnt != 24'hFFFFFF)
        poll_cnt <= poll_cnt + 24'h000001;
      case (state)
        ST_RST_HOLD:
        begin
          if (flash_reset_n_out)
          begin
            state <= ST_IDLE;
            cmd_ready_out <= 1'b1;
          end
        end
        ST_IDLE, ST_SUSPENDED:
        begin
          if (cmd_valid_in && cmd_ready_out)
          begin
            cmd_ready_out <= 1'b0;
            op_addr <= cmd_addr_in;
            op_data <= cmd_data_in;
            fail <= 1'b0;
            rsp_locked_out <= 1'b0;
            seq_op <= cmd_op_in;
            seq_idx <= 3'h0;
            state <= ST_WR_SETUP;
            if (cmd_op_in == OP_PROGRAM || cmd_op_in == OP_SECT_ERASE ||
                cmd_op_in == OP_CHIP_ERASE)
            begin
              poll_addr <= cmd_addr_in;
              op_erase <= (cmd_op_in != OP_PROGRAM);
            end
            if (cmd_op_in == OP_READ)
            begin
              rd_kind <= RD_USER;
              state <= ST_RD_SETUP;
            end
            else if (cmd_op_in == OP_LOCK_QUERY)
              seq_op <= OP_ID_ENTRY;
            else if (state == ST_SUSPENDED)
            begin
              // no second erase while suspended, program only under erase suspend
              if (cmd_op_in == OP_PROGRAM && susp_erase && !nested)
                nested <= 1'b1;
              else if (cmd_op_in != OP_RESUME)
              begin
                fail <= 1'b1;
                state <= ST_FINISH;
              end
            end
            else if (cmd_op_in == OP_RESUME || cmd_op_in > OP_ID_EXIT)
            begin
              fail <= 1'b1;
              state <= ST_FINISH;
            end
          end
        end
        ST_WR_SETUP:
        begin
          flash_bus_out <= '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b1, addr: cur_c.addr,
                             dq: cur_c.data, dq_oe: 1'b1};
          state <= ST_WR_LOW;
        end
        ST_WR_LOW:
        begin
          flash_bus_out.we_n <= 1'b0;
          state <= ST_WR_HOLD;
        end
        ST_WR_HOLD:
        begin
          flash_bus_out.we_n <= 1'b1;
          state <= ST_WR_END;
        end
        ST_WR_END:
        begin
          flash_bus_out <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: flash_bus_out.addr,
                             dq: 16'h0000, dq_oe: 1'b0};
          if (!cur_c.last)
          begin
            seq_idx <= seq_idx + 3'h1;
            state <= ST_WR_SETUP;
          end
          else
          begin
            case (seq_op)
              OP_PROGRAM, OP_SECT_ERASE, OP_CHIP_ERASE, OP_RESUME:
              begin
                if (seq_op == OP_RESUME)
                begin
                  suspended_out <= 1'b0;
                  poll_addr <= susp_addr;
                  op_erase <= susp_erase;
                end
                rd_kind <= RD_POLL_A;
                recheck <= 1'b0;
                poll_cnt <= 24'h000000;
                state <= ST_RD_SETUP;
              end
              OP_SUSPEND:
              begin
                wait_cnt <= susp_erase ? 8'(`ERASE_SUSP_CYC) : 8'(`PROG_SUSP_CYC);
                state <= ST_SUSP_WAIT;
              end
              OP_ID_ENTRY:
              begin
                rd_kind <= RD_LOCK;
                state <= ST_RD_SETUP;
              end
              default:
              begin
                if (seq_op == OP_SET_CFG)
                  status_cfg_out <= op_data[1:0];
                state <= ST_FINISH;
              end
            endcase
          end
        end
        ST_RD_SETUP:
        begin
          flash_bus_out <= '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1, addr: rd_addr,
                             dq: 16'h0000, dq_oe: 1'b0};
          state <= ST_RD_WAIT;
        end
        ST_RD_WAIT:
          state <= ST_RD_CAPT;
        ST_RD_CAPT:
        begin
          flash_bus_out.ce_n <= 1'b1;
          flash_bus_out.oe_n <= 1'b1;
          case (rd_kind)
            RD_USER:
            begin
              rsp_data_out <= flash_dq_in;
              state <= ST_FINISH;
            end
            RD_LOCK:
            begin
              rsp_locked_out <= flash_dq_in[`LOCKED_BIT];
              seq_op <= OP_ID_EXIT;
              seq_idx <= 3'h0;
              state <= ST_WR_SETUP;
            end
            RD_POLL_A:
            begin
              rd_a <= flash_dq_in;
              rd_kind <= RD_POLL_B;
              state <= ST_RD_SETUP;
            end
            default:
            begin
              rd_b <= flash_dq_in;
              state <= ST_POLL_CHK;
            end
          endcase
        end
        ST_POLL_CHK:
        begin
          rd_kind <= RD_POLL_A;
          state <= ST_RD_SETUP;
          rsp_data_out <= rd_b;
          seq_idx <= 3'h0;
          if (!toggled)
          begin
            // stopped toggling: done, status held if failed or in config 01
            if (recheck || (status_cfg_out == `CFG_STAY && err_bits))
              fail <= 1'b1;
            if (recheck || status_cfg_out == `CFG_STAY)
            begin
              seq_op <= OP_ID_EXIT;
              state <= ST_WR_SETUP;
            end
            else
              state <= ST_FINISH;
          end
          else if (err_bits && !recheck)
            recheck <= 1'b1;
          else if (err_bits || poll_cnt >= POLL_LIMIT)
          begin
            fail <= 1'b1;
            seq_op <= OP_ID_EXIT;
            state <= ST_WR_SETUP;
          end
          else if (pending && !suspended_out)
          begin
            susp_addr <= poll_addr;
            susp_erase <= op_erase;
            seq_op <= OP_SUSPEND;
            state <= ST_WR_SETUP;
          end
        end
        ST_SUSP_WAIT:
        begin
          wait_cnt <= wait_cnt - 8'h01;
          if (wait_cnt == 8'h01)
          begin
            suspended_out <= 1'b1;
            state <= ST_FINISH;
          end
        end
        ST_FINISH:
        begin
          rsp_valid_out <= 1'b1;
          rsp_fail_out <= fail;
          cmd_ready_out <= 1'b1;
          nested <= 1'b0;
          state <= suspended_out ? ST_SUSPENDED : ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule : flash_host_ctrl

//--- flash_host_ctrl_chk.sv
// Purpose: port checker for flash_host_ctrl
// Assumes: bound to the controller, one clock domain
// Notes: flash bus timing follows the controller hand-over walk
`timescale 1ns/1ps
module flash_host_ctrl_chk
  import flash_host_pkg::*;
#(parameter logic [23:0] POLL_LIMIT = 24'hFFFFFF)
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_ready_out,
  input wire logic rsp_valid_out,
  input wire logic rsp_fail_out,
  input wire logic suspended_out,
  input wire logic [1:0] status_cfg_out,
  input wire flash_bus_t flash_bus_out,
  input wire logic flash_reset_n_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  ////////////////////////////////////////////////////////////////////////////////
  // user handshake, then flash pin framing, then suspend, config and reset
  property p_take; cmd_valid_in && cmd_ready_out |=> !cmd_ready_out; endproperty
  a_take: assert property (p_take) else $error("ready high after take");
  property p_rsp; rsp_valid_out |=> !rsp_valid_out; endproperty
  a_rsp: assert property (p_rsp) else $error("response longer than a cycle");
  property p_wr; $fell(flash_bus_out.we_n) |-> !flash_bus_out.ce_n && flash_bus_out.oe_n
    && flash_bus_out.dq_oe ##1 $rose(flash_bus_out.we_n) ##1 $rose(flash_bus_out.ce_n); endproperty
  a_wr: assert property (p_wr) else $error("bad write cycle");
  property p_rd; !flash_bus_out.oe_n |-> !flash_bus_out.dq_oe && flash_bus_out.we_n; endproperty
  a_rd: assert property (p_rd) else $error("drive during read");
  // the response pulse comes one edge after suspended_out rises
  property p_susp; $rose(suspended_out) |=> rsp_valid_out && !rsp_fail_out; endproperty
  a_susp: assert property (p_susp) else $error("suspend without response");
  property p_cfg; $changed(status_cfg_out) |-> !$past(cmd_ready_out); endproperty
  a_cfg: assert property (p_cfg) else $error("config moved while idle");
  property p_rst; $rose(rstn_in) |-> !flash_reset_n_out [*5] ##[1:2] flash_reset_n_out; endproperty
  a_rst: assert property (p_rst) else $error("flash reset pulse length");
  property p_hold; !flash_reset_n_out |-> !cmd_ready_out && flash_bus_out.ce_n; endproperty
  a_hold: assert property (p_hold) else $error("activity in flash reset");
endmodule : flash_host_ctrl_chk
bind flash_host_ctrl flash_host_ctrl_chk #(.POLL_LIMIT(POLL_LIMIT)) flash_host_ctrl_chk_inst (
  .sys_clk_in, .rstn_in, .cmd_valid_in, .cmd_ready_out, .rsp_valid_out, .rsp_fail_out,
  .suspended_out, .status_cfg_out, .flash_bus_out, .flash_reset_n_out);

//--- flash_host_map.svh
// Purpose: constants for the parallel flash command controller
// Assumes: 10 MHz controller clock, x16 word mode on the flash
// Notes: command codes and unlock addresses are plain defaults, match them to the part
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH

// clock and timing
`define CLK_PERIOD_NS 100
`define ERASE_SUSP_NS 15000
`define PROG_SUSP_NS 20000
`define RESET_LOW_NS 500
`define CYC_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_SUSP_CYC `CYC_UP(`ERASE_SUSP_NS)
`define PROG_SUSP_CYC `CYC_UP(`PROG_SUSP_NS)
`define RESET_LOW_CYC `CYC_UP(`RESET_LOW_NS)
`define POLL_LIMIT_CYC 24'hFFFFFF

// unlock cycles
`define UNLOCK1_ADDR 21'h000555
`define UNLOCK2_ADDR 21'h0002AA
`define UNLOCK1_DATA 16'h00AA
`define UNLOCK2_DATA 16'h0055

// command data codes
`define PROG_CMD 16'h00A0
`define ERASE_SETUP_CMD 16'h0080
`define SECT_ERASE_CMD 16'h0030
`define CHIP_ERASE_CMD 16'h0010
`define LOCKDOWN_CMD 16'h0060
`define SET_CFG_CMD 16'h00D0
`define ID_ENTRY_CMD 16'h0090
`define ID_EXIT_CMD 16'h00F0
`define SUSPEND_CMD 16'h00B0
`define RESUME_CMD 16'h00D0

// status bit positions and values
`define POLL_BIT 7
`define TOGGLE_BIT 6
`define FAIL_BIT 5
`define SUPPLY_LOW_BIT 3
`define LOCKED_BIT 0
`define LOCK_OFFSET 12'h002
`define CFG_RESET 2'h0
`define CFG_STAY 2'h1

`endif

//--- flash_host_pkg.sv
// Purpose: types shared by the flash command controller
// Assumes: flash_host_map.svh holds the numbers
// Notes: none
package flash_host_pkg;

  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_PROGRAM = 4'h1,
    OP_SECT_ERASE = 4'h2,
    OP_CHIP_ERASE = 4'h3,
    OP_LOCKDOWN = 4'h4,
    OP_LOCK_QUERY = 4'h5,
    OP_SET_CFG = 4'h6,
    OP_RESUME = 4'h7,
    OP_ID_EXIT = 4'h8,
    OP_SUSPEND = 4'h9,
    OP_ID_ENTRY = 4'hA
  } op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_WR_SETUP = 4'h1,
    ST_WR_LOW = 4'h3,
    ST_WR_HOLD = 4'h2,
    ST_WR_END = 4'h6,
    ST_RD_SETUP = 4'h7,
    ST_RD_WAIT = 4'h5,
    ST_RD_CAPT = 4'h4,
    ST_POLL_CHK = 4'hC,
    ST_FINISH = 4'hD,
    ST_SUSP_WAIT = 4'hF,
    ST_SUSPENDED = 4'hE,
    ST_RST_HOLD = 4'hA
  } state_t;

  typedef enum logic [1:0] {
    RD_USER = 2'h0,
    RD_LOCK = 2'h1,
    RD_POLL_A = 2'h2,
    RD_POLL_B = 2'h3
  } rd_kind_t;

  // flash pins driven by the controller
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [20:0] addr;
    logic [15:0] dq;
    logic dq_oe;
  } flash_bus_t;

  // one command bus cycle
  typedef struct packed {
    logic [20:0] addr;
    logic [15:0] data;
    logic last;
  } bus_cycle_t;

endpackage : flash_host_pkg

//--- tb_flash_host_ctrl.sv
// Purpose: self-checking bench for flash_host_ctrl
// Assumes: flash_dev_model on the flash pins, short poll limit
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module tb_flash_host_ctrl;
  import flash_host_pkg::*;
  logic sys_clk_in = 1'h0;
  logic rstn_in = 1'h0;
  logic cmd_valid_in = 1'h0;
  logic suspend_req_in = 1'h0;
  logic supply_low = 1'h0;
  op_t cmd_op_in = OP_READ;
  logic [20:0] cmd_addr_in = 21'h000000;
  logic [15:0] cmd_data_in = 16'h0000;
  logic [15:0] flash_dq_in, rsp_data_out;
  logic cmd_ready_out, rsp_valid_out, rsp_fail_out, rsp_locked_out, suspended_out;
  logic flash_reset_n_out;
  logic [1:0] status_cfg_out;
  flash_bus_t flash_bus_out;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  always #50 sys_clk_in = ~sys_clk_in;
  flash_host_ctrl #(.POLL_LIMIT(24'h000FA0)) flash_host_ctrl_inst (.sys_clk_in, .rstn_in,
    .cmd_valid_in, .cmd_op_in, .cmd_addr_in, .cmd_data_in, .suspend_req_in, .cmd_ready_out,
    .rsp_valid_out, .rsp_fail_out, .rsp_data_out, .rsp_locked_out, .suspended_out,
    .status_cfg_out, .flash_bus_out, .flash_dq_in, .flash_reset_n_out);
  flash_dev_model flash_dev_model_inst (.clk_in(sys_clk_in), .bus_in(flash_bus_out),
    .reset_n_in(flash_reset_n_out), .supply_low_in(supply_low), .dq_out(flash_dq_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // request held until the edge that takes it
  task automatic issue(input op_t op, input logic [20:0] a, input logic [15:0] d);
    while (cmd_ready_out !== 1'b1) @(negedge sys_clk_in);
    cmd_op_in = op;
    cmd_addr_in = a;
    cmd_data_in = d;
    cmd_valid_in = 1'b1;
    @(negedge sys_clk_in);
    cmd_valid_in = 1'b0;
  endtask : issue
  task automatic run(input op_t op, input logic [20:0] a, input logic [15:0] d, input logic f);
    if (op != OP_RESUME || f) issue(op, a, d);
    while (rsp_valid_out !== 1'b1) @(negedge sys_clk_in);
    chk("fail", {15'h0000, f}, {15'h0000, rsp_fail_out});
  endtask : run
  task automatic rd(input logic [20:0] a, input logic [15:0] exp);
    run(OP_READ, a, 16'h0000, 1'b0);
    chk("data", exp, rsp_data_out);
  endtask : rd
  task automatic reset_dut;
    rstn_in = 1'b0;
    repeat (6) @(negedge sys_clk_in);
    rstn_in = 1'b1;
  endtask : reset_dut
  task automatic t_prog_erase;
    run(OP_PROGRAM, 21'h001010, 16'h1234, 1'b0);
    rd(21'h001010, 16'h1234);
    run(OP_PROGRAM, 21'h001010, 16'hFF00, 1'b0);
    rd(21'h001010, 16'h1200);
    run(OP_SECT_ERASE, 21'h001000, 16'h0000, 1'b0);
    rd(21'h001010, 16'hFFFF);
    run(OP_PROGRAM, 21'h001010, 16'h0F0F, 1'b0);
    run(OP_CHIP_ERASE, 21'h001000, 16'h0000, 1'b0);
    rd(21'h001010, 16'hFFFF);
  endtask : t_prog_erase
  task automatic t_lock;
    run(OP_LOCKDOWN, 21'h002000, 16'h0000, 1'b0);
    run(OP_LOCK_QUERY, 21'h002000, 16'h0000, 1'b0);
    chk("locked", 16'h0001, {15'h0000, rsp_locked_out});
    run(OP_LOCK_QUERY, 21'h001000, 16'h0000, 1'b0);
    chk("locked", 16'h0000, {15'h0000, rsp_locked_out});
    run(OP_PROGRAM, 21'h002005, 16'h0000, 1'b1);
    rd(21'h002005, 16'hFFFF);
    run(OP_SECT_ERASE, 21'h002000, 16'h0000, 1'b1);
    supply_low = 1'b1;
    run(OP_PROGRAM, 21'h001010, 16'h0000, 1'b1);
    supply_low = 1'b0;
    reset_dut();
    run(OP_LOCK_QUERY, 21'h002000, 16'h0000, 1'b0);
    chk("locked", 16'h0000, {15'h0000, rsp_locked_out});
  endtask : t_lock
  task automatic t_cfg;
    run(OP_SET_CFG, 21'h000000, 16'h0001, 1'b0);
    chk("cfg", 16'h0001, {14'h0000, status_cfg_out});
    run(OP_PROGRAM, 21'h001020, 16'h00A5, 1'b0);
    rd(21'h001020, 16'h00A5);
    run(OP_SET_CFG, 21'h000000, 16'h0000, 1'b0);
    chk("cfg", 16'h0000, {14'h0000, status_cfg_out});
  endtask : t_cfg
  // suspend an erase, then a program, read elsewhere, resume
  task automatic t_susp;
    for (int i = 0; i < 2; i++)
    begin
      issue(i ? OP_PROGRAM : OP_SECT_ERASE, i ? 21'h004030 : 21'h003000, 16'h3C3C);
      repeat (i ? 22 : 40) @(negedge sys_clk_in);
      suspend_req_in = 1'b1;
      @(negedge sys_clk_in);
      suspend_req_in = 1'b0;
      run(OP_RESUME, 21'h000000, 16'h0000, 1'b0);
      chk("suspended", 16'h0001, {15'h0000, suspended_out});
      rd(21'h001020, 16'h00A5);
      run(OP_SECT_ERASE, 21'h005000, 16'h0000, 1'b1);
      issue(OP_RESUME, 21'h000000, 16'h0000);
      run(OP_RESUME, 21'h000000, 16'h0000, 1'b0);
      chk("suspended", 16'h0000, {15'h0000, suspended_out});
    end
    rd(21'h004030, 16'h3C3C);
  endtask : t_susp
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  always @(posedge sys_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      give_verdict();
    end
  end
  initial
  begin
    reset_dut();
    chk("cfg", 16'h0000, {14'h0000, status_cfg_out});
    run(OP_RESUME, 21'h000000, 16'h0000, 1'b1);
    run(OP_ID_EXIT, 21'h000000, 16'h0000, 1'b0);
    t_prog_erase();
    t_lock();
    t_cfg();
    t_susp();
    give_verdict();
  end
endmodule : tb_flash_host_ctrl
